// ### design/ans_pkg.sv
package ans_pkg;

    // ----------------------------------------
    // Management addressing
    // ----------------------------------------
    localparam logic [4:0]  ANS_DEV_ADDR     = 5'h07;
    localparam logic [15:0] ANS_OFS_STATUS   = 16'h0001;
    localparam logic [15:0] ANS_OFS_PRESENCE = 16'h0005;
    localparam logic [15:0] ANS_OFS_ADV_LOW  = 16'h0010;
    localparam logic [15:0] ANS_OFS_ADV_MID  = 16'h0011;

    // ----------------------------------------
    // Reset and fixed values
    // ----------------------------------------
    localparam logic [15:0] ANS_STATUS_RST   = 16'h0088;
    localparam logic [15:0] ANS_PRESENCE_VAL = 16'h0080;
    localparam logic [15:0] ANS_ADV_LOW_RST  = 16'h1001;
    localparam logic [15:0] ANS_ADV_MID_RST  = 16'h0080;
    localparam logic [15:0] ANS_ADV_LOW_WMSK = 16'hBFFF;
    localparam logic [15:0] ANS_LFSR_TAPS    = 16'hB400;

    // ----------------------------------------
    // Status and advertisement field positions
    // ----------------------------------------
    localparam int ANS_ST_PDF  = 9;
    localparam int ANS_ST_EXT  = 7;
    localparam int ANS_ST_PAGE = 6;
    localparam int ANS_ST_DONE = 5;
    localparam int ANS_ST_RF   = 4;
    localparam int ANS_ST_ABLE = 3;
    localparam int ANS_ST_LINK = 2;
    localparam int ANS_ST_LP   = 0;
    localparam int ANS_ADV_ACK = 14;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ans_mgmt_req_type;

    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
    } ans_mgmt_rsp_type;

    typedef struct packed {
        logic       par_det_fault;
        logic       page_arrived;
        logic       done;
        logic       remote_fault;
        logic       link_up;
        logic       ext_page;
        logic       partner_capable;
        logic       nonce_exchanged;
        logic [4:0] partner_nonce;
    } ans_engine_type;

endpackage : ans_pkg

// ### design/ans_regs.sv
`timescale 1ns/10ps

// Notes on behaviour
// - Parallel detect fault latches high, read-only
// - Page arrival latches high, read-only
// - Done bit follows negotiation completion
// - Far-end fault latches high, read-only
// - Capability bit always reads one
// - Extended page bit, one after reset
// - Partner capability shown read-only
// - Presence register reads 0x0080
// - Writable next-page bit drives D15
// - Acknowledge bit reads zero, read-only
// - Writable fault bit drives D13
// - Pause bits drive D12:D10, reset 100
// - Echo sent until nonces exchanged
// - Echo field reads last written value
// - Selector drives D4:D0, reset 00001
// - Ability bits 15:8 drive D31:D24
// - Bit 7 drives D23, reset one
// - Bit 5 drives D21, reset zero
// - Nonce from random generator, reads written
// - Only device address 0x07 accepted
module ans_regs #(
    parameter logic [15:0] NONCE_SEED = 16'hACE1
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,
    input  wire ans_pkg::ans_mgmt_req_type mgmt_req,
    output      ans_pkg::ans_mgmt_rsp_type mgmt_rsp,
    input  wire ans_pkg::ans_engine_type   engine,
    output      logic [31:0]               base_codeword
);
    import ans_pkg::*;

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (NONCE_SEED == 16'h0000) begin : g_seed_chk
        $error("nonce seed must be non-zero");
    end

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic        hit;
    logic        rd_hit;
    logic        wr_hit;
    logic        rd_status;
    logic        pdf_q;
    logic        page_q;
    logic        rf_q;
    logic        link_q;
    logic        ext_q;
    logic [15:0] adv_low_q;
    logic [15:0] adv_mid_q;
    logic [15:0] lfsr_q;
    logic [15:0] status_val;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic [31:0] codeword_d;
    logic [31:0] codeword_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Frames for other devices are ignored
    assign hit       = clk_en && (mgmt_req.dev == ANS_DEV_ADDR);
    assign rd_hit    = hit && mgmt_req.rd;
    assign wr_hit    = hit && mgmt_req.wr && !mgmt_req.rd;
    assign rd_status = rd_hit && (mgmt_req.addr == ANS_OFS_STATUS);

    // ----------------------------------------
    // Latched status bits
    // ----------------------------------------
    // Sticky until a status read; a new event in the read cycle survives
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pdf_q  <= 1'b0;
            page_q <= 1'b0;
            rf_q   <= 1'b0;
            link_q <= 1'b0;
        end else if (clk_en) begin
            pdf_q  <= (pdf_q && !rd_status) || engine.par_det_fault;
            page_q <= (page_q && !rd_status) || engine.page_arrived;
            rf_q   <= (rf_q && !rd_status) || engine.remote_fault;
            link_q <= (link_q || rd_status) && engine.link_up;      // Latched low
        end
    end

    // Extended page indication, one out of reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_q <= ANS_STATUS_RST[ANS_ST_EXT];
        end else if (clk_en) begin
            ext_q <= engine.ext_page;
        end
    end

    // ----------------------------------------
    // Advertisement registers
    // ----------------------------------------
    // Acknowledge position is masked off on write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            adv_low_q <= ANS_ADV_LOW_RST;
        end else if (wr_hit && mgmt_req.addr == ANS_OFS_ADV_LOW) begin
            adv_low_q <= mgmt_req.wdata & ANS_ADV_LOW_WMSK;
        end
    end

    // Whole word writable, nonce field kept for readback only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            adv_mid_q <= ANS_ADV_MID_RST;
        end else if (wr_hit && mgmt_req.addr == ANS_OFS_ADV_MID) begin
            adv_mid_q <= mgmt_req.wdata;
        end
    end

    // ----------------------------------------
    // Nonce generator
    // ----------------------------------------
    // Free-running Galois shift register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_q <= NONCE_SEED;
        end else if (clk_en) begin
            lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ ANS_LFSR_TAPS) : (lfsr_q >> 1);
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Status word assembly and read mux
    always_comb begin
        status_val              = 16'h0000;
        status_val[ANS_ST_PDF]  = pdf_q;
        status_val[ANS_ST_EXT]  = ext_q;
        status_val[ANS_ST_PAGE] = page_q;
        status_val[ANS_ST_DONE] = engine.done;
        status_val[ANS_ST_RF]   = rf_q;
        status_val[ANS_ST_ABLE] = 1'b1;
        status_val[ANS_ST_LINK] = link_q;
        status_val[ANS_ST_LP]   = engine.partner_capable;
        case (mgmt_req.addr)
            ANS_OFS_STATUS:   rdata_d = status_val;
            ANS_OFS_PRESENCE: rdata_d = ANS_PRESENCE_VAL;
            ANS_OFS_ADV_LOW:  rdata_d = adv_low_q;
            ANS_OFS_ADV_MID:  rdata_d = adv_mid_q;
            default:          rdata_d = 16'h0000;
        endcase
    end

    // Read answer one enabled cycle after the request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 16'h0000;
        end else if (clk_en) begin
            rvalid_q <= rd_hit;
            if (rd_hit) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign mgmt_rsp.rvalid = rvalid_q;
    assign mgmt_rsp.rdata  = rdata_q;

    // ----------------------------------------
    // Base codeword
    // ----------------------------------------
    // Echo swaps to partner nonce once nonces are exchanged
    always_comb begin
        codeword_d        = {adv_mid_q[15:5], lfsr_q[4:0], adv_low_q};
        codeword_d[14]    = 1'b0;
        if (engine.nonce_exchanged) begin
            codeword_d[9:5] = engine.partner_nonce;
        end
    end

    // Registered codeword towards the engine
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            codeword_q <= {ANS_ADV_MID_RST[15:5], 5'h00, ANS_ADV_LOW_RST};
        end else if (clk_en) begin
            codeword_q <= codeword_d;
        end
    end

    assign base_codeword = codeword_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic st_read_q; // Last answered read was the status word

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_read_q <= 1'b0;
        end else if (clk_en) begin
            st_read_q <= rd_status;
        end
    end

    a_pdf_latch_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        pdf_q && !rd_status |=> pdf_q
    ) else $error("parallel fault latch dropped without a read");

    a_page_set_wins: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && engine.page_arrived |=> page_q
    ) else $error("page arrival not latched");

    a_rf_read_back: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && engine.remote_fault && rd_status |=> rf_q
    ) else $error("far-end fault lost when set during a status read");

    a_status_fixed_bits: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mgmt_rsp.rvalid && st_read_q |-> mgmt_rsp.rdata[ANS_ST_ABLE]
            && mgmt_rsp.rdata[15:10] == 6'h00
    ) else $error("status fixed bits wrong");

    a_done_tracks: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_status ##1 mgmt_rsp.rvalid |-> mgmt_rsp.rdata[ANS_ST_DONE] == $past(engine.done)
    ) else $error("done bit does not follow negotiation");

    a_presence_value: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_hit && mgmt_req.addr == ANS_OFS_PRESENCE |=> mgmt_rsp.rdata == ANS_PRESENCE_VAL
    ) else $error("presence register wrong");

    a_foreign_dev: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && mgmt_req.rd && mgmt_req.dev != ANS_DEV_ADDR |=> !mgmt_rsp.rvalid
    ) else $error("answered a frame for another device");

    a_ack_zero: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !base_codeword[14] && !adv_low_q[ANS_ADV_ACK]
    ) else $error("acknowledge position not zero");

    a_echo_source: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en ##1 1'b1 |-> base_codeword[9:5] == ($past(engine.nonce_exchanged)
            ? $past(engine.partner_nonce) : $past(adv_low_q[9:5]))
    ) else $error("echo field source wrong");

    a_echo_readback: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_hit && mgmt_req.addr == ANS_OFS_ADV_LOW ##1 !wr_hit ##1 $past(rd_hit)
            && $past(mgmt_req.addr) == ANS_OFS_ADV_LOW
        |-> mgmt_rsp.rdata[9:5] == $past(mgmt_req.wdata[9:5], 2)
    ) else $error("echo readback not the written value");

    a_nonce_random: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en |=> base_codeword[20:16] == $past(lfsr_q[4:0])
    ) else $error("sent nonce not from generator");

    a_ability_map: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en |=> base_codeword[31:21] == $past(adv_mid_q[15:5])
    ) else $error("ability bits misplaced in codeword");

    a_pdf_set_wins: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && engine.par_det_fault |=> pdf_q
    ) else $error("parallel fault not latched");

    a_page_latch_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        page_q && !rd_status |=> page_q
    ) else $error("page latch dropped without a read");

    a_rf_latch_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rf_q && !rd_status |=> rf_q
    ) else $error("far-end fault latch dropped without a read");

    a_ext_follows: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en |=> ext_q == $past(engine.ext_page)
    ) else $error("extended page bit does not follow engine");

    a_partner_live: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_status |=> mgmt_rsp.rdata[ANS_ST_LP] == $past(engine.partner_capable)
    ) else $error("partner capability bit wrong on status read");

    a_read_refresh: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_status && !engine.page_arrived |=> !page_q
    ) else $error("page latch not refreshed by status read");

endmodule : ans_regs

// ### tb/ans_engine_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Negotiation engine stand-in
// ----------------------------------------
module ans_engine_model (
    input  wire logic [2:0]              fire,
    input  wire logic [4:0]              lvl,
    input  wire logic [4:0]              nonce,
    output      ans_pkg::ans_engine_type engine
);
    import ans_pkg::*;

    // Event pulses follow the requests, levels follow lvl
    assign engine.par_det_fault   = fire[2];
    assign engine.page_arrived    = fire[1];
    assign engine.remote_fault    = fire[0];
    assign engine.done            = lvl[4];
    assign engine.link_up         = lvl[3];
    assign engine.ext_page        = lvl[2];
    assign engine.partner_capable = lvl[1];
    assign engine.nonce_exchanged = lvl[0];
    // Nonce is only valid once exchanged, stale value shown inverted
    assign engine.partner_nonce   = lvl[0] ? nonce : ~nonce;
endmodule : ans_engine_model

// ### tb/ans_regs_bench.sv
`timescale 1ns/10ps

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t got %h want %h", $time, (a), (b)); end end

module ans_regs_bench;
    import ans_pkg::*;

    logic             clk_sys = 1'b0;
    logic             rst_n   = 1'b0;
    logic             clk_en  = 1'b1;
    ans_mgmt_req_type req     = '0;
    ans_mgmt_rsp_type rsp;
    ans_engine_type   eng;
    logic [31:0]      cw;
    logic [2:0]       fire    = 3'h0;
    logic [4:0]       lvl     = 5'h04;
    logic [4:0]       nonce   = 5'h00;
    logic [31:0]      lfsr    = 32'hC699DDC2;
    logic [15:0]      lo;
    logic [15:0]      mid;
    logic [15:0]      expq[$];
    logic [15:0]      want;
    logic [31:0]      cw_want;
    int               bad_count       = 0;
    int               samples_checked = 0;

    always #20 clk_sys = ~clk_sys;

    ans_regs i_dut (
        .clk_sys       (clk_sys),
        .rst_n         (rst_n),
        .clk_en        (clk_en),
        .mgmt_req      (req),
        .mgmt_rsp      (rsp),
        .engine        (eng),
        .base_codeword (cw)
    );

    ans_engine_model i_eng (
        .fire   (fire),
        .lvl    (lvl),
        .nonce  (nonce),
        .engine (eng)
    );

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    task automatic stop_test;
        $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Read request held one cycle, expectation noted for the monitor when d is ANS_DEV_ADDR
    task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [4:0] d = 5'h07);
        if (d === ANS_DEV_ADDR) begin
            expq.push_back(e);
        end
        req.rd   = 1'b1;
        req.wr   = 1'b0;
        req.dev  = d;
        req.addr = a;
        @(negedge clk_sys);
    endtask : rd

    // Write request held one cycle; the next call or idle releases it
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        req.rd    = 1'b0;
        req.wr    = 1'b1;
        req.dev   = ANS_DEV_ADDR;
        req.addr  = a;
        req.wdata = v;
        @(negedge clk_sys);
    endtask : wr

    // Event lines held one cycle; the next call or idle releases them
    task automatic pulse(input logic [2:0] f);
        fire = f;
        @(negedge clk_sys);
    endtask : pulse

    // Bus and event lines back to rest, then n quiet cycles
    task automatic idle(input int n);
        req.rd = 1'b0;
        req.wr = 1'b0;
        fire   = 3'h0;
        repeat (n) @(negedge clk_sys);
    endtask : idle

    // Monitor: each answer is matched with the oldest expectation
    always @(negedge clk_sys) begin
        if (rsp.rvalid === 1'b1) begin
            if (expq.size() == 0) begin
                bad_count++;
                $display("BAD %0t unexpected answer", $time);
            end else begin
                want = expq.pop_front();
                `CHK(rsp.rdata, want)
            end
        end
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        `CHK(cw & 32'hFFE0FFFF, 32'h00801001)
        rd(ANS_OFS_STATUS, ANS_STATUS_RST);
        rd(ANS_OFS_PRESENCE, ANS_PRESENCE_VAL);
        rd(ANS_OFS_ADV_LOW, ANS_ADV_LOW_RST);
        rd(ANS_OFS_ADV_MID, ANS_ADV_MID_RST);
        rd(16'h0002, 16'h0000);
        rd(ANS_OFS_STATUS, 16'h0000, 5'h03);
        wr(ANS_OFS_STATUS, 16'hFFFF);
        wr(ANS_OFS_PRESENCE, 16'h0000);
        rd(ANS_OFS_PRESENCE, ANS_PRESENCE_VAL);
        rd(ANS_OFS_STATUS, ANS_STATUS_RST);
        // Latched events, then live done and partner bits
        lvl = 5'h16;
        idle(1);
        pulse(3'b100);
        pulse(3'b010);
        pulse(3'b001);
        idle(1);
        rd(ANS_OFS_STATUS, 16'h02F9);
        rd(ANS_OFS_STATUS, 16'h00A9);
        lvl = 5'h02;
        idle(2);
        rd(ANS_OFS_STATUS, 16'h0009);
        // Far-end fault raised in a status read cycle survives, link re-armed
        lvl  = 5'h0A;
        fire = 3'b001;
        rd(ANS_OFS_STATUS, 16'h0009);
        fire = 3'h0;
        rd(ANS_OFS_STATUS, 16'h001D);
        // Random advertisements, with and without nonce exchange
        for (int i = 0; i < 6; i++) begin
            lfsr = nxt(lfsr);
            lo = lfsr[15:0];
            mid = lfsr[31:16] & 16'hFFBF;
            nonce = lfsr[24:20];
            lvl = {4'h1, i[0]};
            wr(ANS_OFS_ADV_LOW, lo);
            rd(ANS_OFS_ADV_LOW, lo & ANS_ADV_LOW_WMSK);
            wr(ANS_OFS_ADV_MID, mid);
            idle(2);
            cw_want = {mid[15:5], 5'h00, lo[15], 1'b0, lo[13:10], i[0] ? nonce : lo[9:5], lo[4:0]};
            `CHK(cw & 32'hFFE0FFFF, cw_want)
            rd(ANS_OFS_ADV_MID, mid);
        end
        // Frozen block refuses a write and keeps its registers
        idle(1);
        clk_en = 1'b0;
        wr(ANS_OFS_ADV_MID, ~mid & 16'hFFBF);
        idle(2);
        clk_en = 1'b1;
        rd(ANS_OFS_ADV_MID, mid);
        idle(1);
        for (int k = 0; k < 10 && expq.size() > 0; k++) begin
            @(negedge clk_sys);
        end
        if (expq.size() > 0) begin
            bad_count++;
            $display("BAD %0t answers missing", $time);
        end
        stop_test();
    end
endmodule : ans_regs_bench
